// file: inc/mpc_pkg.sv
// Package of register map, fields and address ranges for the protection block
package mpc_pkg;
  // Register byte offsets
  localparam logic [11:0] OFS_INFO = 12'hd90;
  localparam logic [11:0] OFS_CTRL = 12'hd94;
  localparam logic [11:0] OFS_REGION = 12'hda0;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'hdc0;
  localparam logic [11:0] OFS_IRQ_MASK = 12'hdc4;
  localparam logic [11:0] OFS_FAULT_ADDR = 12'hdc8;
  // Information register fields
  localparam logic [7:0] INSTR_REGION_COUNT = 8'h00;
  localparam logic [7:0] DATA_REGION_COUNT = 8'h08;
  localparam logic SPLIT_MAP = 1'b0;
  localparam int NUM_REGIONS = 8;
  // Control register fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_ESC_BIT = 1;
  localparam int CTRL_BG_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  // Region config layout: enable in bit 0, size code 5:1, base 31:5
  localparam int REG_SIZE_LSB = 1;
  localparam int REG_SIZE_MSB = 5;
  localparam int REG_BASE_LSB = 5;
  // Interrupt status bits
  localparam int IRQ_FAULT_BIT = 0;
  localparam int IRQ_PRIV_BIT = 1;
  localparam int IRQ_BITS = 2;
  // System control space and vector table ranges
  localparam logic [31:0] SCS_BASE = 32'he000e000;
  localparam logic [31:0] SCS_LAST = 32'he000efff;
  localparam logic [31:0] VTAB_BASE = 32'h00000000;
  localparam logic [31:0] VTAB_LAST = 32'h000003ff;
  // Default map: execute-never at and above this address
  localparam logic [31:0] DEF_XN_BASE = 32'ha0000000;
  // Priority codes of normal and escalated handlers
  typedef enum logic [1:0] {
    MPC_PRI_NORMAL = 2'h0,
    MPC_PRI_NMI = 2'h1,
    MPC_PRI_HARD = 2'h2,
    MPC_PRI_FMASK = 2'h3
  } mpc_pri_e;
endpackage : mpc_pkg

// file: design/mpc_region_match.sv
// Region address matcher for all protection regions
module mpc_region_match (
  // Region configuration
  input wire logic [32*mpc_pkg::NUM_REGIONS-1:0] region_cfg,
  // Access address
  input wire logic [31:0] addr,
  // Match per region
  output logic [mpc_pkg::NUM_REGIONS-1:0] hit
);
  genvar g;
  generate
    for (g = 0; g < mpc_pkg::NUM_REGIONS; g++) begin : g_reg
      logic [31:0] cfg;
      logic [4:0] size_code;
      logic [31:0] mask;
      assign cfg = region_cfg[32*g +: 32];
      assign size_code = cfg[mpc_pkg::REG_SIZE_MSB:mpc_pkg::REG_SIZE_LSB];
      // Region spans 2^(size+1) bytes
      assign mask = (size_code == 5'h1f) ? 32'h00000000 :
                    (32'hffffffff << (6'(size_code) + 6'h01));
      assign hit[g] = cfg[0] &&
                      ((addr & mask) == ({cfg[31:mpc_pkg::REG_BASE_LSB],
                       5'h00} & mask));
    end
  endgenerate
endmodule : mpc_region_match

// file: design/mpc_access_check.sv
// Per-access permission decision, combinational
module mpc_access_check (
  // Control state
  input wire logic prot_en,
  input wire logic esc_en,
  input wire logic bg_en,
  // Access attributes
  input wire logic privileged,
  input wire logic fetch,
  input wire logic [1:0] priority_kind,
  input wire logic [31:0] addr,
  input wire logic any_hit,
  // Decision
  output logic fault,
  output logic scs_attr,
  output logic xn
);
  logic in_scs;
  logic in_vtab;
  logic escalated;
  logic active;
  assign in_scs = addr >= mpc_pkg::SCS_BASE && addr <= mpc_pkg::SCS_LAST;
  assign in_vtab = addr <= mpc_pkg::VTAB_LAST;
  // Escalated priorities only from these handler kinds
  assign escalated = priority_kind != mpc_pkg::MPC_PRI_NORMAL; // [R13]
  assign active = prot_en && (!escalated || esc_en); // [R12]
  // Never-execute and strongly ordered regardless of enable
  assign scs_attr = in_scs; // [R08]
  assign xn = in_scs || addr >= mpc_pkg::DEF_XN_BASE; // [R08]
  always_comb begin
    fault = 1'b0;
    if (fetch && xn) begin
      fault = 1'b1; // [R08]
    end else if (!active) begin
      fault = 1'b0; // [R10]
    end else if (in_scs || in_vtab) begin
      fault = 1'b0; // [R11]
    end else if (any_hit) begin
      fault = 1'b0; // [R15]
    end else if (privileged && bg_en) begin
      fault = 1'b0; // [R06]
    end else begin
      fault = 1'b1; // [R07]
    end
  end
endmodule : mpc_access_check

// file: design/mpc_top.sv
// Protection unit information, control, regions and fault interrupt
// Notes on behaviour
// [R01] Register access only from privileged code
// [R02] Instruction region count reads zero
// [R03] Data region count reads eight
// [R04] Split-map flag reads zero, unified
// [R05] Reserved information bits read zero
// [R06] Privileged miss uses default map with background
// [R07] Unprivileged miss faults when enabled
// [R08] System space always never-execute, strongly ordered
// [R09] Software enables a region unless background
// [R10] Disabled: default map for everyone
// [R11] System space and vector table always allowed
// [R12] Escalated handlers bypass unless escalation bit
// [R13] Escalation only from hard fault, NMI, mask
// [R14] Control bits 2,1,0 reset to zero
// [R15] Background map is lowest priority region
// [R16] Software avoids escalation bit while disabled
// [R17] Decision same cycle, fault before completion; acc_fault to the core is registered, one cycle after acc_valid
//
// Added by the designer: the APB slave port.
module mpc_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [2:0] pprot,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core access port
  input wire logic acc_valid,
  input wire logic [31:0] acc_addr,
  input wire logic acc_privileged,
  input wire logic acc_fetch,
  input wire logic [1:0] acc_priority_kind,
  // Decision to core
  output logic acc_fault,
  output logic acc_scs_attr,
  output logic acc_xn,
  // Interrupt
  output logic irq
);
  logic [2:0] ctrl;
  logic [31:0] region_cfg [mpc_pkg::NUM_REGIONS];
  logic [32*mpc_pkg::NUM_REGIONS-1:0] region_flat;
  logic [mpc_pkg::IRQ_BITS-1:0] irq_status;
  logic [mpc_pkg::IRQ_BITS-1:0] irq_mask;
  logic [31:0] fault_addr;
  logic [mpc_pkg::NUM_REGIONS-1:0] hit;
  logic fault_now;
  logic scs_now;
  logic xn_now;
  logic setup;
  logic bus_priv;
  logic wr_ok;
  logic rd_ok;
  logic addr_known;
  logic is_region;
  logic [2:0] region_idx;
  logic priv_err;
  logic [31:0] next_prdata;
  logic [mpc_pkg::IRQ_BITS-1:0] events;

  genvar g;
  generate
    for (g = 0; g < mpc_pkg::NUM_REGIONS; g++) begin : g_flat
      assign region_flat[32*g +: 32] = region_cfg[g];
    end
  endgenerate

  mpc_region_match u_match (
    .region_cfg(region_flat),
    .addr(acc_addr),
    .hit(hit)
  );

  mpc_access_check u_check (
    .prot_en(ctrl[mpc_pkg::CTRL_EN_BIT]),
    .esc_en(ctrl[mpc_pkg::CTRL_ESC_BIT]),
    .bg_en(ctrl[mpc_pkg::CTRL_BG_BIT]),
    .privileged(acc_privileged),
    .fetch(acc_fetch),
    .priority_kind(acc_priority_kind),
    .addr(acc_addr),
    .any_hit(|hit),
    .fault(fault_now),
    .scs_attr(scs_now),
    .xn(xn_now)
  );

  // Bus decode; answer on first access cycle
  assign setup = psel && !penable;
  assign bus_priv = pprot[0];
  assign is_region = paddr >= mpc_pkg::OFS_REGION &&
                     paddr < mpc_pkg::OFS_IRQ_STATUS;
  assign region_idx = paddr[4:2];
  assign addr_known = is_region || paddr == mpc_pkg::OFS_INFO ||
                      paddr == mpc_pkg::OFS_CTRL ||
                      paddr == mpc_pkg::OFS_IRQ_STATUS ||
                      paddr == mpc_pkg::OFS_IRQ_MASK ||
                      paddr == mpc_pkg::OFS_FAULT_ADDR;
  assign priv_err = !bus_priv || !addr_known; // [R01]
  // Writes commit at the access edge, when pready is sampled high
  assign wr_ok = psel && penable && pready && pwrite && !priv_err; // [R01]
  assign rd_ok = setup && !pwrite && !priv_err; // [R01]

  always_comb begin
    next_prdata = 32'h00000000;
    if (is_region) begin
      next_prdata = region_cfg[region_idx];
    end else begin
      case (paddr)
        mpc_pkg::OFS_INFO: begin
          next_prdata = {8'h00, // [R05]
                         mpc_pkg::INSTR_REGION_COUNT, // [R02]
                         mpc_pkg::DATA_REGION_COUNT, // [R03]
                         7'h00, // [R05]
                         mpc_pkg::SPLIT_MAP}; // [R04]
        end
        mpc_pkg::OFS_CTRL: next_prdata = {29'h0, ctrl};
        mpc_pkg::OFS_IRQ_STATUS: next_prdata = {30'h0, irq_status};
        mpc_pkg::OFS_IRQ_MASK: next_prdata = {30'h0, irq_mask};
        mpc_pkg::OFS_FAULT_ADDR: next_prdata = fault_addr;
        default: next_prdata = 32'h00000000;
      endcase
    end
  end

  // APB answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      pslverr <= setup && priv_err; // [R01]
      prdata <= rd_ok ? next_prdata : 32'h00000000;
    end
  end

  // Control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= mpc_pkg::CTRL_RESET; // [R14]
    end else if (wr_ok && paddr == mpc_pkg::OFS_CTRL) begin
      ctrl <= pwdata[2:0]; // [R14]
    end
  end

  // Region configuration store
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < mpc_pkg::NUM_REGIONS; i++) begin
        region_cfg[i] <= 32'h00000000;
      end
    end else if (wr_ok && is_region) begin
      region_cfg[region_idx] <= pwdata;
    end
  end

  // Access decision registered toward core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_fault <= 1'b0;
      acc_scs_attr <= 1'b0;
      acc_xn <= 1'b0;
    end else begin
      acc_fault <= acc_valid && fault_now; // [R17]
      acc_scs_attr <= acc_valid && scs_now; // [R08]
      acc_xn <= acc_valid && xn_now; // [R08]
    end
  end

  assign events[mpc_pkg::IRQ_FAULT_BIT] = acc_valid && fault_now;
  assign events[mpc_pkg::IRQ_PRIV_BIT] = setup && !bus_priv;

  // Sticky status, set wins over write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= '0;
    end else begin
      irq_status <= events | (irq_status &
        ~((wr_ok && paddr == mpc_pkg::OFS_IRQ_STATUS) ?
          pwdata[mpc_pkg::IRQ_BITS-1:0] : '0));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= '0;
    end else if (wr_ok && paddr == mpc_pkg::OFS_IRQ_MASK) begin
      irq_mask <= pwdata[mpc_pkg::IRQ_BITS-1:0];
    end
  end

  // Fault address capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_addr <= 32'h00000000;
    end else if (acc_valid && fault_now) begin
      fault_addr <= acc_addr; // [R17]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end
endmodule : mpc_top

// file: testbench/mpc_top_asserts.sv
// Checker of protection unit decisions and register reads
module mpc_top_asserts (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [2:0] pprot,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Core side
  input wire logic acc_valid,
  input wire logic [31:0] acc_addr,
  input wire logic acc_fetch,
  input wire logic [1:0] acc_priority_kind,
  input wire logic acc_fault,
  input wire logic acc_scs_attr,
  input wire logic acc_xn,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [2:0] ctrl;
  logic setup;
  logic scs;
  logic data_acc;
  assign setup = psel && !penable && pprot[0];
  assign scs = acc_addr >= mpc_pkg::SCS_BASE && acc_addr <= mpc_pkg::SCS_LAST;
  assign data_acc = acc_valid && !acc_fetch;
  // Shadow of the control bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= 3'h0;
    end else if (psel && penable && pready && pprot[0] && pwrite &&
                 paddr == mpc_pkg::OFS_CTRL) begin
      ctrl <= pwdata[2:0];
    end
  end
  a_unpriv_refused: assert property (
    psel && !penable && !pprot[0] |=> pslverr && prdata == 32'h0)
    else $error("Unprivileged access not refused");
  a_info_value: assert property (
    setup && !pwrite && paddr == mpc_pkg::OFS_INFO |=> prdata == 32'h800)
    else $error("Information register value wrong");
  a_ctrl_value: assert property (
    setup && !pwrite && paddr == mpc_pkg::OFS_CTRL |=> prdata == {29'h0, ctrl})
    else $error("Control register value wrong");
  a_scs_attrs: assert property (
    acc_valid && scs |=> acc_scs_attr && acc_xn)
    else $error("System space attributes missing");
  a_fetch_xn: assert property (
    acc_valid && acc_fetch && acc_addr >= mpc_pkg::DEF_XN_BASE |=> acc_fault)
    else $error("Fetch from never-execute not faulted");
  a_always_allowed: assert property (
    data_acc && (scs || acc_addr <= mpc_pkg::VTAB_LAST) |=> !acc_fault)
    else $error("System space or vector table faulted");
  a_disabled_open: assert property (
    data_acc && !ctrl[0] |=> !acc_fault)
    else $error("Fault while protection disabled");
  a_escal_bypass: assert property (
    data_acc && acc_priority_kind != 2'h0 && !ctrl[1] |=> !acc_fault)
    else $error("Escalated handler not bypassed");
  a_idle_quiet: assert property (
    !acc_valid |=> !acc_fault && !acc_xn && !acc_scs_attr)
    else $error("Decision without access");
  c_fault: cover property (acc_fault);
  c_irq: cover property (irq);
  c_refused: cover property (pslverr);
endmodule : mpc_top_asserts

bind mpc_top mpc_top_asserts i_chk (.*);

// file: testbench/mpc_core_model.sv
// Core model issuing one access at a time
module mpc_core_model (
  // Clock
  input wire logic pclk,
  // Access request
  output logic acc_valid,
  output logic [31:0] acc_addr,
  output logic acc_privileged,
  output logic acc_fetch,
  output logic [1:0] acc_priority_kind
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    acc_valid = 1'b0;
    acc_addr = 32'h0;
    acc_privileged = 1'b0;
    acc_fetch = 1'b0;
    acc_priority_kind = 2'h0;
  end
  task automatic access(input logic [31:0] a, input logic p, f,
                        input logic [1:0] k);
    @(posedge pclk);
    acc_valid <= 1'b1;
    acc_addr <= a;
    acc_privileged <= p;
    acc_fetch <= f;
    acc_priority_kind <= k;
    @(posedge pclk);
    acc_valid <= 1'b0;
    acc_addr <= ~a;
  endtask : access
endmodule : mpc_core_model

// file: testbench/tb.sv
// Testbench of the protection unit block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [2:0] pprot = 3'h0;
  logic [31:0] prdata, rd, acc_addr;
  logic pready, pslverr, irq, er, acc_valid, acc_privileged, acc_fetch;
  logic acc_fault, acc_scs_attr, acc_xn;
  logic [1:0] acc_priority_kind;
  int errors = 0;
  int n_tests = 0;
  int cycles = 0;
  mpc_top i_dut (.*);
  mpc_core_model i_core (.*);
  initial begin
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      end_sim();
    end
  end
  task end_sim;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  task chk(input string nm, input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           input logic p);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pprot <= {2'h0, p};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task acc(input logic [31:0] a, input logic p, f, input logic [1:0] k,
           input logic ef);
    i_core.access(a, p, f, k);
    #1;
    chk("fault", 32'(acc_fault), 32'(ef));
  endtask : acc
  task t_regs;
    apb(0, mpc_pkg::OFS_INFO, 0, 1);
    chk("info", rd, 32'h800);
    apb(0, mpc_pkg::OFS_CTRL, 0, 1);
    chk("ctrl reset", rd, 32'h0);
    apb(1, mpc_pkg::OFS_CTRL, 32'hffffffff, 1);
    apb(0, mpc_pkg::OFS_CTRL, 0, 1);
    chk("ctrl bits", rd, 32'h7);
    apb(1, mpc_pkg::OFS_CTRL, 0, 1);
    apb(1, mpc_pkg::OFS_INFO, 32'hffffffff, 1);
    apb(0, mpc_pkg::OFS_INFO, 0, 1);
    chk("info ro", rd, 32'h800);
    $display("test regs done");
  endtask : t_regs
  task t_priv;
    apb(0, mpc_pkg::OFS_INFO, 0, 0);
    chk("unpriv err", 32'(er), 1);
    chk("unpriv data", rd, 0);
    apb(1, mpc_pkg::OFS_CTRL, 32'h5, 0);
    apb(0, mpc_pkg::OFS_CTRL, 0, 1);
    chk("ctrl kept", rd, 0);
    apb(0, 12'hd98, 0, 1);
    chk("unmapped", 32'(er), 1);
    $display("test priv done");
  endtask : t_priv
  task t_map;
    acc(32'h20000000, 0, 0, 0, 0);
    acc(32'he000e010, 0, 1, 0, 1);
    chk("scs attr", 32'({acc_xn, acc_scs_attr}), 3);
    apb(1, mpc_pkg::OFS_CTRL, 32'h5, 1);
    acc(32'h20000000, 1, 0, 0, 0);
    acc(32'h20000000, 0, 0, 0, 1);
    apb(0, mpc_pkg::OFS_IRQ_STATUS, 0, 1);
    chk("status", 32'(rd[0]), 1);
    chk("irq masked", 32'(irq), 0);
    apb(1, mpc_pkg::OFS_IRQ_MASK, 32'h1, 1);
    @(posedge pclk);
    #1;
    chk("irq on", 32'(irq), 1);
    apb(1, mpc_pkg::OFS_IRQ_STATUS, 32'h3, 1);
    @(posedge pclk);
    #1;
    chk("irq off", 32'(irq), 0);
    acc(32'h00000100, 0, 0, 0, 0);
    acc(32'he000e010, 0, 0, 0, 0);
    $display("test map done");
  endtask : t_map
  task t_region;
    apb(1, mpc_pkg::OFS_CTRL, 0, 1);
    apb(1, mpc_pkg::OFS_REGION, 32'h20000013, 1);
    apb(1, mpc_pkg::OFS_CTRL, 32'h1, 1);
    acc(32'h20000010, 0, 0, 0, 0);
    acc(32'h20000400, 0, 0, 0, 1);
    acc(32'h30000000, 1, 0, 0, 1);
    apb(1, mpc_pkg::OFS_CTRL, 32'h5, 1);
    acc(32'h20000010, 0, 0, 0, 0);
    apb(0, mpc_pkg::OFS_FAULT_ADDR, 0, 1);
    chk("fault addr", rd, 32'h30000000);
    $display("test region done");
  endtask : t_region
  task t_esc;
    apb(1, mpc_pkg::OFS_CTRL, 32'h1, 1);
    for (int k = 1; k < 4; k++) acc(32'h30000000, 0, 0, k[1:0], 0);
    acc(32'h30000000, 0, 0, 0, 1);
    apb(1, mpc_pkg::OFS_CTRL, 32'h3, 1);
    for (int k = 1; k < 4; k++) acc(32'h30000000, 0, 0, k[1:0], 1);
    apb(1, mpc_pkg::OFS_CTRL, 32'h4, 1);
    acc(32'h30000000, 0, 0, 0, 0);
    $display("test escalation done");
  endtask : t_esc
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_priv();
    t_map();
    t_region();
    t_esc();
    end_sim();
  end
endmodule : tb
